// ===== hdl/fbs_top.sv
/*
  Flash boot start select: reset start address choice, program map
  decode, flash array with byte access and erase, APB registers.
  Assumes strap pins are asynchronous levels resolved by the board and
  that the APB runs on core_clk.
*/
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.svh"

module fbs_top #(
  parameter int MEM_BYTES = 65536
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap pins, asynchronous
  input wire logic program_fetch_strobe_n,
  input wire logic port2_bit7_strap,
  input wire logic external_access_select,
  input wire logic ale_strap,
  // Program fetch request from the core and the registered answer
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  output fbs_pkg::fbs_target_t fetch_target,
  output logic [2:0] fetch_block,
  output logic fetch_done,
  // Chosen start
  output logic [15:0] start_addr,
  output logic start_valid,
  output logic start_vectored
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] flash_mem [MEM_BYTES]; // Program flash bytes
  logic [7:0] start_page_reg = `FBS_START_PAGE_RST; // Nonvolatile page pointer, factory value
  logic [7:0] boot_flag_reg = `FBS_BOOT_FLAG_RST; // Nonvolatile boot select flag, factory value
  logic rom_en_reg; // Boot ROM overlay enable
  logic [15:0] fl_addr_reg; // Flash operation address
  logic [7:0] fl_data_reg; // Program data or read result
  logic [15:0] erase_ptr_reg; // Erase walk pointer
  logic [15:0] erase_end_reg; // Last address to erase
  fbs_pkg::fbs_state_t state_reg; // Sequencer state

  // Strap synchronisers
  logic [3:0] strap_s1_reg; // First stage, read only by second
  logic [3:0] strap_s2_reg; // Safe strap levels

  // Capture state
  logic captured_reg; // Start choice taken this reset
  logic ext_only_reg; // Internal program memory disabled
  logic strap_force_reg; // Strap combination seen at release

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic acc; // Access completes this edge
  logic wr_acc; // Write completes
  logic mapped; // Address hits a register
  logic busy; // Erase walk in progress
  logic [2:0] cmd; // Command field of a command write
  logic cmd_wr; // Accepted command write

  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite && !pslverr;
  assign busy = (state_reg == fbs_pkg::FBS_ST_ERASE);
  assign cmd = pwdata[2:0];
  assign cmd_wr = wr_acc && paddr == `FBS_OFF_FL_CMD;

  // Register hit check
  always_comb begin
    case (paddr)
      `FBS_OFF_START_PAGE, `FBS_OFF_BOOT_FLAG, `FBS_OFF_CTRL,
      `FBS_OFF_STATUS, `FBS_OFF_FL_ADDR, `FBS_OFF_FL_DATA,
      `FBS_OFF_FL_CMD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Answer one cycle into the access phase; unmapped, or a write other than CTRL while busy, is an error
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      // Writes to flash state during an erase walk would race it
      pslverr <= !mapped || (pwrite && busy && paddr != `FBS_OFF_CTRL);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Read data, prepared while pready is being raised
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      case (paddr)
        `FBS_OFF_START_PAGE: prdata <= {24'h000000, start_page_reg};
        `FBS_OFF_BOOT_FLAG: prdata <= {24'h000000, boot_flag_reg};
        `FBS_OFF_CTRL: prdata <= {31'h0000_0000, rom_en_reg};
        `FBS_OFF_STATUS: prdata <= {8'h00, start_addr, 3'h0,
          strap_force_reg, ext_only_reg, start_vectored, captured_reg, busy};
        `FBS_OFF_FL_ADDR: prdata <= {16'h0000, fl_addr_reg};
        `FBS_OFF_FL_DATA: prdata <= {24'h000000, fl_data_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control and address registers
  // ----------------------------------------------------------------
  // Boot ROM enable comes up set so the loader is reachable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rom_en_reg <= 1'b1;
    end else if (wr_acc && paddr == `FBS_OFF_CTRL) begin
      rom_en_reg <= pwdata[`FBS_CTRL_ROM_EN];
    end
  end

  // Flash operation address
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fl_addr_reg <= 16'h0000;
    end else if (wr_acc && paddr == `FBS_OFF_FL_ADDR) begin
      fl_addr_reg <= pwdata[15:0];
    end
  end

  // Data register: software writes it, a read command loads it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fl_data_reg <= 8'h00;
    end else if (cmd_wr && cmd == `FBS_CMD_READ) begin
      fl_data_reg <= flash_mem[fl_addr_reg];
    end else if (wr_acc && paddr == `FBS_OFF_FL_DATA) begin
      fl_data_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Special nonvolatile bytes
  // ----------------------------------------------------------------
  // Power-up value stands in for factory contents; chip reset keeps them,
  // so a flag written before a reset is what the next release looks at
  always_ff @(posedge core_clk) begin
    if (cmd_wr && cmd == `FBS_CMD_PAIR_ERASE) begin
      // One erase clears both bytes, whichever was aimed at
      start_page_reg <= `FBS_ERASED_BYTE;
      boot_flag_reg <= `FBS_ERASED_BYTE;
    end else if (wr_acc && paddr == `FBS_OFF_START_PAGE) begin
      start_page_reg <= pwdata[7:0];
    end else if (wr_acc && paddr == `FBS_OFF_BOOT_FLAG) begin
      boot_flag_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Flash sequencer
  // ----------------------------------------------------------------
  // Erase walks one byte per cycle; slow but needs no wide write port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= fbs_pkg::FBS_ST_IDLE;
      erase_ptr_reg <= 16'h0000;
      erase_end_reg <= 16'h0000;
    end else begin
      case (state_reg)
        fbs_pkg::FBS_ST_IDLE: begin
          if (cmd_wr && cmd == `FBS_CMD_BLK_ERASE) begin
            // Any address inside the block selects it
            erase_ptr_reg <= fbs_pkg::fbs_block_base(
              fbs_pkg::fbs_block_of(fl_addr_reg));
            erase_end_reg <= (fbs_pkg::fbs_block_of(fl_addr_reg) == 3'h4)
              ? `FBS_TOP_ADDR
              : fbs_pkg::fbs_block_base(3'(fbs_pkg::fbs_block_of(fl_addr_reg)
                + 3'h1)) - 16'h0001;
            state_reg <= fbs_pkg::FBS_ST_ERASE;
          end else if (cmd_wr && cmd == `FBS_CMD_CHIP_ERASE) begin
            erase_ptr_reg <= `FBS_APP_ENTRY;
            erase_end_reg <= `FBS_TOP_ADDR;
            state_reg <= fbs_pkg::FBS_ST_ERASE;
          end
        end
        fbs_pkg::FBS_ST_ERASE: begin
          if (erase_ptr_reg == erase_end_reg) begin
            state_reg <= fbs_pkg::FBS_ST_IDLE;
          end else begin
            erase_ptr_reg <= erase_ptr_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= fbs_pkg::FBS_ST_IDLE;
        end
      endcase
    end
  end

  // Array write port: erase walk or byte program
  always_ff @(posedge core_clk) begin
    if (busy) begin
      flash_mem[erase_ptr_reg] <= `FBS_ERASED_BYTE;
    end else if (cmd_wr && cmd == `FBS_CMD_PROG) begin
      flash_mem[fl_addr_reg] <= fl_data_reg;
    end
  end

  // ----------------------------------------------------------------
  // Strap sampling and start capture
  // ----------------------------------------------------------------
  // Free running so the levels are settled when reset falls
  always_ff @(posedge core_clk) begin
    strap_s1_reg <= {program_fetch_strobe_n, port2_bit7_strap,
      external_access_select, ale_strap};
    strap_s2_reg <= strap_s1_reg;
  end

  // Taken at the first edge after release, then frozen until reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      captured_reg <= 1'b0;
      ext_only_reg <= 1'b0;
      strap_force_reg <= 1'b0;
      start_addr <= `FBS_APP_ENTRY;
      start_valid <= 1'b0;
      start_vectored <= 1'b0;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      start_valid <= 1'b1;
      ext_only_reg <= !strap_s2_reg[1];
      // Fetch strobe low, P2 bit high, access select high, ALE high
      strap_force_reg <= !strap_s2_reg[3] && strap_s2_reg[2]
        && strap_s2_reg[1] && strap_s2_reg[0];
      if (boot_flag_reg == 8'h00 && !(!strap_s2_reg[3] && strap_s2_reg[2]
          && strap_s2_reg[1] && strap_s2_reg[0])) begin
        start_addr <= `FBS_APP_ENTRY;
        start_vectored <= 1'b0;
      end else begin
        start_addr <= {start_page_reg, `FBS_LOW_BYTE_ZERO};
        start_vectored <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fetch decode
  // ----------------------------------------------------------------
  fbs_pkg::fbs_target_t dec_target; // Combinational target
  logic [2:0] dec_block; // Combinational block

  fbs_map_decode u_map (
    .addr(fetch_addr),
    .boot_rom_en(rom_en_reg),
    .ext_only(ext_only_reg),
    .target(dec_target),
    .block(dec_block)
  );

  // Registered answer one cycle after each request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fetch_target <= fbs_pkg::FBS_TGT_FLASH;
      fetch_block <= 3'h0;
      fetch_done <= 1'b0;
    end else begin
      fetch_done <= fetch_valid;
      if (fetch_valid) begin
        fetch_target <= dec_target;
        fetch_block <= dec_block;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rom_overlay: assert property (@(posedge core_clk) disable iff (reset)
    fetch_valid && !ext_only_reg && rom_en_reg && fetch_addr >= `FBS_BOOT_ROM_BASE
    |=> fetch_target == fbs_pkg::FBS_TGT_BOOT_ROM)
    else $error("boot ROM window not served by ROM");

  a_rom_off_flash: assert property (@(posedge core_clk) disable iff (reset)
    fetch_valid && !ext_only_reg && !rom_en_reg
    |=> fetch_target == fbs_pkg::FBS_TGT_FLASH)
    else $error("disabled ROM still overlays");

  a_low_blocks: assert property (@(posedge core_clk) disable iff (reset)
    fetch_valid && fetch_addr < 16'h4000
    |=> fetch_block == {2'b00, $past(fetch_addr[13])})
    else $error("8K block numbering wrong");

  a_high_blocks: assert property (@(posedge core_clk) disable iff (reset)
    fetch_valid && fetch_addr >= 16'h4000
    |=> fetch_block == 3'($past(fetch_addr[15:14]) + 2'h0) + 3'h1)
    else $error("16K block numbering wrong");

  a_external_only: assert property (@(posedge core_clk) disable iff (reset)
    fetch_valid && ext_only_reg |=> fetch_target == fbs_pkg::FBS_TGT_EXTERNAL)
    else $error("fetch not external with access select low");

  a_app_start: assert property (@(posedge core_clk) disable iff (reset)
    !captured_reg && boot_flag_reg == 8'h00 && strap_s2_reg != 4'b0111
    |=> start_addr == 16'h0000 && !start_vectored)
    else $error("zero flag did not start at zero");

  a_vector_start: assert property (@(posedge core_clk) disable iff (reset)
    !captured_reg && boot_flag_reg != 8'h00
    |=> start_addr == {$past(start_page_reg), 8'h00} && start_vectored)
    else $error("vectored start address wrong");

  a_strap_force: assert property (@(posedge core_clk) disable iff (reset)
    !captured_reg && strap_s2_reg == 4'b0111 |=> start_vectored && strap_force_reg)
    else $error("strap combination ignored");

  a_start_held: assert property (@(posedge core_clk) disable iff (reset)
    captured_reg |=> $stable(start_addr) && $stable(start_vectored) && start_valid)
    else $error("start choice changed before reset");

  a_pair_erase: assert property (@(posedge core_clk) disable iff (reset)
    cmd_wr && cmd == `FBS_CMD_PAIR_ERASE
    |=> start_page_reg == `FBS_ERASED_BYTE && boot_flag_reg == `FBS_ERASED_BYTE)
    else $error("pair erase left a byte");

  a_erase_done: assert property (@(posedge core_clk) disable iff (reset)
    busy && erase_ptr_reg == erase_end_reg |=> !busy)
    else $error("erase walk overran its end");

endmodule

`default_nettype wire

// ===== hdl/fbs_defs.svh
/*
  Constants of the flash boot start select block: register offsets,
  reset values, memory map edges and flash command codes.
  Assumes it is included by bare name from the package and modules.
*/
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------
`define FBS_OFF_START_PAGE 8'h00
`define FBS_OFF_BOOT_FLAG 8'h04
`define FBS_OFF_CTRL 8'h08
`define FBS_OFF_STATUS 8'h0C
`define FBS_OFF_FL_ADDR 8'h10
`define FBS_OFF_FL_DATA 8'h14
`define FBS_OFF_FL_CMD 8'h18

// ----------------------------------------------------------------
// Reset and erased values
// ----------------------------------------------------------------
`define FBS_START_PAGE_RST 8'hFC
`define FBS_BOOT_FLAG_RST 8'h00
`define FBS_ERASED_BYTE 8'hFF
`define FBS_LOW_BYTE_ZERO 8'h00
`define FBS_APP_ENTRY 16'h0000

// ----------------------------------------------------------------
// Memory map edges
// ----------------------------------------------------------------
`define FBS_BLK1_BASE 16'h2000
`define FBS_BLK2_BASE 16'h4000
`define FBS_BLK3_BASE 16'h8000
`define FBS_BLK4_BASE 16'hC000
`define FBS_BOOT_ROM_BASE 16'hFC00
`define FBS_TOP_ADDR 16'hFFFF

// ----------------------------------------------------------------
// Control bits and flash command codes
// ----------------------------------------------------------------
`define FBS_CTRL_ROM_EN 0
`define FBS_CMD_READ 3'h1
`define FBS_CMD_PROG 3'h2
`define FBS_CMD_BLK_ERASE 3'h3
`define FBS_CMD_CHIP_ERASE 3'h4
`define FBS_CMD_PAIR_ERASE 3'h5

`endif

// ===== hdl/fbs_pkg.sv
/*
  Types and shared decode helpers of the flash boot start select block.
  Assumes fbs_defs.svh is on the include path.
*/
`include "fbs_defs.svh"

package fbs_pkg;

  // Where a program fetch is served
  typedef enum logic [1:0] {
    FBS_TGT_FLASH,
    FBS_TGT_BOOT_ROM,
    FBS_TGT_EXTERNAL
  } fbs_target_t;

  // Flash operation sequencer states
  typedef enum logic [1:0] {
    FBS_ST_IDLE,
    FBS_ST_ERASE
  } fbs_state_t;

  // Block number of a program address
  function automatic logic [2:0] fbs_block_of(input logic [15:0] addr);
    if (addr < `FBS_BLK1_BASE) begin
      return 3'h0;
    end else if (addr < `FBS_BLK2_BASE) begin
      return 3'h1;
    end else if (addr < `FBS_BLK3_BASE) begin
      return 3'h2;
    end else if (addr < `FBS_BLK4_BASE) begin
      return 3'h3;
    end else begin
      return 3'h4;
    end
  endfunction

  // First address of a block
  function automatic logic [15:0] fbs_block_base(input logic [2:0] blk);
    case (blk)
      3'h0: return `FBS_APP_ENTRY;
      3'h1: return `FBS_BLK1_BASE;
      3'h2: return `FBS_BLK2_BASE;
      3'h3: return `FBS_BLK3_BASE;
      default: return `FBS_BLK4_BASE;
    endcase
  endfunction

endpackage

// ===== hdl/fbs_map_decode.sv
/*
  Program fetch address decoder: flash, overlay boot ROM or external.
  Assumes its inputs are registered selections held in the core domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.svh"

module fbs_map_decode (
  // Fetch address
  input wire logic [15:0] addr,
  // Captured selections
  input wire logic boot_rom_en,
  input wire logic ext_only,
  // Decode result
  output fbs_pkg::fbs_target_t target,
  output logic [2:0] block
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // External access wins over everything, then the ROM overlay
  always_comb begin
    block = fbs_pkg::fbs_block_of(addr);
    if (ext_only) begin
      target = fbs_pkg::FBS_TGT_EXTERNAL;
    end else if (boot_rom_en && addr >= `FBS_BOOT_ROM_BASE) begin
      target = fbs_pkg::FBS_TGT_BOOT_ROM;
    end else begin
      target = fbs_pkg::FBS_TGT_FLASH;
    end
  end

endmodule

`default_nettype wire

// ===== sim/fbs_strap_model.sv
/*
  Board strapping seen by the flash boot start select block.
  Assumes the bench sets the four strap choices while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none

module fbs_strap_model (
  // Strap choices from the bench
  input wire logic fetch_low,
  input wire logic p27_high,
  input wire logic acc_sel_high,
  input wire logic ale_low,
  // Strap pins toward the block
  output logic program_fetch_strobe_n,
  output logic port2_bit7_strap,
  output logic external_access_select,
  output logic ale_strap
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // A latch strobe left open floats, so the board pull-up decides
  tri1 ale_net;
  assign ale_net = ale_low ? 1'b0 : 1'bz;
  assign ale_strap = ale_net;
  // Plain driven straps
  assign program_fetch_strobe_n = ~fetch_low;
  assign port2_bit7_strap = p27_high;
  assign external_access_select = acc_sel_high;
endmodule

`default_nettype wire

// ===== sim/flash_boot_start_select_test.sv
/*
  Self-checking bench of the flash boot start select block.
  Assumes fbs_pkg, fbs_defs.svh, fbs_top and the strap model are built.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.svh"

module flash_boot_start_select_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fetch_valid = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00, d1;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] fetch_addr = 16'h0, start_addr, a1, a2;
  fbs_pkg::fbs_target_t fetch_target;
  logic [2:0] fetch_block;
  logic fetch_done, start_valid, start_vectored;
  // Strap choices and pins
  logic s_fl = 1'b0, s_p7 = 1'b0, s_acc = 1'b1, s_al = 1'b0;
  logic strobe_n, p27, acc_sel, ale;
  int num_errors = 0, n_compared = 0;
  // Map edges, both sides of every block border
  logic [15:0] corner [12] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000, 16'h7FFF,
                               16'h8000, 16'hBFFF, 16'hC000, 16'hFBFF, 16'hFC00, 16'hFFFF};

  always #2 core_clk = ~core_clk;

  fbs_strap_model strap_u (.fetch_low(s_fl), .p27_high(s_p7), .acc_sel_high(s_acc), .ale_low(s_al),
    .program_fetch_strobe_n(strobe_n), .port2_bit7_strap(p27), .external_access_select(acc_sel),
    .ale_strap(ale));

  fbs_top dut_u (.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .program_fetch_strobe_n(strobe_n), .port2_bit7_strap(p27),
    .external_access_select(acc_sel), .ale_strap(ale), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_target(fetch_target), .fetch_block(fetch_block),
    .fetch_done(fetch_done), .start_addr(start_addr), .start_valid(start_valid),
    .start_vectored(start_vectored));

  // ----------------------------------------
  // Expectations and checks
  // ----------------------------------------
  // Two 8K blocks, then three 16K blocks
  function automatic logic [2:0] exp_blk(input logic [15:0] a);
    return (a < 16'h4000) ? {2'b00, a[13]} : {1'b0, a[15:14]} + 3'h1;
  endfunction

  // External beats everything, then the top 1K overlay
  function automatic fbs_pkg::fbs_target_t exp_tgt(input logic [15:0] a, input logic rom, input logic ext);
    if (ext) begin
      return fbs_pkg::FBS_TGT_EXTERNAL;
    end
    return (rom && a >= 16'hFC00) ? fbs_pkg::FBS_TGT_BOOT_ROM : fbs_pkg::FBS_TGT_FLASH;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Sample pready at each rising edge, as the slave's own edge sees it
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1, "no bus answer");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll the erase busy flag with a bound
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, `FBS_OFF_STATUS, 0);
      k++;
    end while (rd[0] !== 1'b0 && k < 20000);
    chk(rd[0], 0, "erase never ends");
  endtask

  task automatic flash_wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, `FBS_OFF_FL_ADDR, {16'h0, a});
    apb(1'b1, `FBS_OFF_FL_DATA, {24'h0, d});
    apb(1'b1, `FBS_OFF_FL_CMD, `FBS_CMD_PROG);
  endtask

  task automatic flash_rd(input logic [15:0] a, input logic [7:0] e);
    apb(1'b1, `FBS_OFF_FL_ADDR, {16'h0, a});
    apb(1'b1, `FBS_OFF_FL_CMD, `FBS_CMD_READ);
    apb(1'b0, `FBS_OFF_FL_DATA, 0);
    chk(rd[7:0], e, "flash byte");
  endtask

  // One fetch; answer is registered at the taking edge and checked half a cycle later
  task automatic fetch(input logic [15:0] a, input logic rom, input logic ext);
    @(posedge core_clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge core_clk);
    fetch_valid <= 1'b0;
    @(negedge core_clk);
    chk(fetch_done, 1, "fetch done");
    chk(fetch_target, exp_tgt(a, rom, ext), "fetch target");
    if (!ext) begin
      chk(fetch_block, exp_blk(a), "fetch block");
    end
  endtask

  // Straps settle while reset is held six cycles; capture edge follows
  task automatic do_reset(input logic fl, input logic p7, input logic e, input logic al);
    @(posedge core_clk);
    reset <= 1'b1;
    s_fl <= fl;
    s_p7 <= p7;
    s_acc <= e;
    s_al <= al;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(start_valid, 1, "start captured");
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hFA44));
    // Defaults after reset
    do_reset(1'b0, 1'b0, 1'b1, 1'b0);
    chk(start_addr, 16'h0000, "app start");
    chk(start_vectored, 0, "not vectored");
    apb(1'b0, `FBS_OFF_START_PAGE, 0);
    chk(rd, 32'hFC, "page default");
    apb(1'b0, `FBS_OFF_BOOT_FLAG, 0);
    chk(rd, 32'h0, "flag default");
    apb(1'b0, 8'h40, 0);
    chk(er, 1, "unmapped refused");
    $display("test defaults done");
    // Map with overlay on, then off; corners plus random fetches
    for (int r = 1; r >= 0; r--) begin
      apb(1'b1, `FBS_OFF_CTRL, 32'(r));
      foreach (corner[i]) fetch(corner[i], r[0], 1'b0);
      repeat (30) fetch(16'($urandom), r[0], 1'b0);
    end
    $display("test map done");
    // Later writes must not move the captured start
    apb(1'b1, `FBS_OFF_BOOT_FLAG, 32'h5A);
    apb(1'b1, `FBS_OFF_START_PAGE, {24'h0, 8'($urandom)});
    chk({start_vectored, start_addr}, 17'h0, "start held");
    // Pair erase clears both bytes, then software restores them
    apb(1'b1, `FBS_OFF_FL_CMD, `FBS_CMD_PAIR_ERASE);
    wait_idle();
    apb(1'b0, `FBS_OFF_BOOT_FLAG, 0);
    chk(rd, 32'hFF, "flag erased");
    apb(1'b0, `FBS_OFF_START_PAGE, 0);
    chk(rd, 32'hFF, "page erased");
    apb(1'b1, `FBS_OFF_START_PAGE, 32'hFC);
    apb(1'b1, `FBS_OFF_BOOT_FLAG, 32'h0);
    apb(1'b0, `FBS_OFF_START_PAGE, 0);
    chk(rd, 32'hFC, "page rewritten");
    $display("test pair erase done");
    // Byte program and read, block erase with a refused write, chip erase
    a1 = {3'b001, 13'($urandom)};
    a2 = {2'b10, 14'($urandom)};
    d1 = 8'($urandom);
    flash_wr(a1, d1);
    flash_rd(a1, d1);
    flash_wr(a2, ~d1);
    // The erasing code fetches from block three before block one is cleared
    fetch(a2, 1'b0, 1'b0);
    apb(1'b1, `FBS_OFF_FL_ADDR, {16'h0, a1});
    apb(1'b1, `FBS_OFF_FL_CMD, `FBS_CMD_BLK_ERASE);
    apb(1'b1, `FBS_OFF_FL_DATA, 32'h33);
    chk(er, 1, "write refused while busy");
    wait_idle();
    flash_rd(a1, 8'hFF);
    flash_rd(a2, ~d1);
    apb(1'b1, `FBS_OFF_FL_CMD, `FBS_CMD_CHIP_ERASE);
    wait_idle();
    flash_rd(a2, 8'hFF);
    $display("test flash done");
    // Strap force, then a near miss with the latch strobe pulled low
    do_reset(1'b1, 1'b1, 1'b1, 1'b0);
    chk({start_vectored, start_addr}, 17'h1FC00, "strap vectored");
    do_reset(1'b1, 1'b1, 1'b1, 1'b1);
    chk({start_vectored, start_addr}, 17'h0, "ale low no force");
    // Nonzero flag kept across reset starts at the written page
    apb(1'b1, `FBS_OFF_START_PAGE, {24'h0, d1});
    apb(1'b1, `FBS_OFF_BOOT_FLAG, 32'($urandom_range(255, 1)));
    do_reset(1'b0, 1'b0, 1'b1, 1'b0);
    chk({start_vectored, start_addr}, {1'b1, d1, 8'h00}, "flag vectored");
    apb(1'b1, `FBS_OFF_BOOT_FLAG, 32'h0);
    $display("test straps done");
    // External access low: no force, every fetch goes outside
    do_reset(1'b1, 1'b1, 1'b0, 1'b0);
    chk({start_vectored, start_addr}, 17'h0, "access low no force");
    foreach (corner[i]) fetch(corner[i], 1'b1, 1'b1);
    repeat (20) fetch(16'($urandom), 1'b1, 1'b1);
    $display("test external done");
    results();
  end

  // Watchdog: the erases dominate, well under this span
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    $display("unexpected at %0t: run hung", $time);
    results();
  end
endmodule

`default_nettype wire
